// *** inc/rtwoc_defines.svh ***
// Register offsets, field positions, reset values and divider counts of the reload timer.
`ifndef RTWOC_DEFINES_SVH
`define RTWOC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RTWOC_OFS_CTRL     8'h00
`define RTWOC_OFS_CLKCTL   8'h04
`define RTWOC_OFS_RLD_LO   8'h08
`define RTWOC_OFS_RLD_HI   8'h0C
`define RTWOC_OFS_CNT_LO   8'h10
`define RTWOC_OFS_CNT_HI   8'h14
`define RTWOC_OFS_EV_STAT  8'h18
`define RTWOC_OFS_EV_MASK  8'h1C
`define RTWOC_OFS_TIRQ_EN  8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RTWOC_CTL_HOF      7
`define RTWOC_CTL_LOF      6
`define RTWOC_CTL_LIE      5
`define RTWOC_CTL_CAP      4
`define RTWOC_CTL_SPLIT    3
`define RTWOC_CTL_RUN      2
`define RTWOC_CTL_EXT      0
`define RTWOC_CKC_HSEL     7
`define RTWOC_CKC_LSEL     6
`define RTWOC_EV_HOF       0
`define RTWOC_EV_LOF       1
`define RTWOC_EV_CAP       2
`define RTWOC_EV_W         3
`define RTWOC_TIE_BIT      0

// ----------------------------------------------------------------------------
// Reset values and divider counts
// ----------------------------------------------------------------------------
`define RTWOC_BYTE_RST     8'h00
`define RTWOC_EV_RST       3'h0
`define RTWOC_DIV12_LAST   4'hB
`define RTWOC_EXT_DIV_W    3

`endif

// *** inc/rtwoc_pkg.sv ***
// Types shared by the reload timer design files.
package rtwoc_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef logic [7:0] rtwoc_byte_type;

   typedef enum logic [2:0] {
      RTWOC_SRC_SYS   = 3'h1,
      RTWOC_SRC_DIV12 = 3'h2,
      RTWOC_SRC_EXT8  = 3'h4
   } rtwoc_src_type;

endpackage : rtwoc_pkg

// *** hw/rtwoc_clk_src.sv ***
// Divided clock enables and capture events for the reload timer.
`timescale 1ns/1ps
`default_nettype none
`include "rtwoc_defines.svh"

module rtwoc_clk_src
   import rtwoc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ext_osc,
   output logic      div12_tick,
   output logic      ext8_tick,
   output logic      ext8_fall
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   logic [3:0]                  div_q,  div_d;
   logic                        sy1_q,  sy2_q,  prv_q;
   logic [`RTWOC_EXT_DIV_W-1:0] ocnt_q, ocnt_d;
   logic                        d8p_q;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      div_d  = (div_q == `RTWOC_DIV12_LAST) ? 4'h0 : div_q + 4'h1;
      ocnt_d = (sy2_q && !prv_q) ? ocnt_q + 1'b1 : ocnt_q;
   end

   // The first synchroniser stage feeds only the second stage.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q  <= 4'h0;
         sy1_q  <= 1'b0;
         sy2_q  <= 1'b0;
         prv_q  <= 1'b0;
         ocnt_q <= '0;
         d8p_q  <= 1'b0;
      end else begin
         div_q  <= div_d;
         sy1_q  <= ext_osc;
         sy2_q  <= sy1_q;
         prv_q  <= sy2_q;
         ocnt_q <= ocnt_d;
         d8p_q  <= ocnt_q[`RTWOC_EXT_DIV_W-1];
      end
   end

   assign div12_tick = (div_q == `RTWOC_DIV12_LAST); // RQ2
   assign ext8_tick  = ocnt_q[`RTWOC_EXT_DIV_W-1] && !d8p_q; // RQ2
   assign ext8_fall  = !ocnt_q[`RTWOC_EXT_DIV_W-1] && d8p_q; // RQ14

endmodule : rtwoc_clk_src
`default_nettype wire

// *** hw/rtwoc_byte_cnt.sv ***
// One 8-bit counter byte with reload and software write.
`timescale 1ns/1ps
`default_nettype none

module rtwoc_byte_cnt
   import rtwoc_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire logic           inc,
   input  wire logic           load,
   input  wire rtwoc_byte_type load_val,
   input  wire logic           wr,
   input  wire rtwoc_byte_type wr_val,
   output rtwoc_byte_type      cnt_q,
   output logic               wrap
);

   rtwoc_byte_type cnt_d;

   // A software write wins over the counter's own step.
   always_comb begin
      if (wr) begin
         cnt_d = wr_val;
      end else if (load) begin
         cnt_d = load_val;
      end else if (inc) begin
         cnt_d = cnt_q + 8'h01;
      end else begin
         cnt_d = cnt_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign wrap = inc && (cnt_q == 8'hFF);

endmodule : rtwoc_byte_cnt
`default_nettype wire

// *** hw/rtwoc_top.sv ***
// Auto-reload timer with split mode and external oscillator capture.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rtwoc_defines.svh"

// Functional notes
// RQ1: Sixteen-bit counter of two bytes; split select picks one 16-bit or two 8-bit.
// RQ2: Counter clock is system clock, system clock /12, or synchronised external /8.
// RQ3: Sixteen-bit overflow loads both reload bytes and sets the high flag; in capture mode the code sets the flag without reloading.
// RQ4: Sixteen-bit mode requests an interrupt on each full overflow when enabled.
// RQ5: With low-byte interrupt enable, a low byte wrap also requests an interrupt.
// RQ6: In split mode each byte reloads from its own reload byte on its wrap.
// RQ7: In split mode run gates only the high byte; low byte always counts.
// RQ8: Per-byte select 1 gives system clock, else external select picks /12 or /8.
// RQ9: In split mode each byte wrap sets its own overflow flag.
// RQ10: Split mode interrupts on high wrap, and on either wrap with low enable.
// RQ11: Flags are never cleared by hardware; software clears and inspects both.
// RQ12: Capture mode clocks the counter at system clock or system clock /12.
// RQ13: A capture copies the 16-bit count into the reload bytes, sets high flag.
// RQ14: Capture events come on falling edges of the synchronised external /8.
// RQ15: Software keeps 16-bit mode and a fast counter clock during capture.
// RQ16: Software derives oscillator rate from two successive captured values.
// RQ17: Capture enable is control bit 4; one enables capture, zero disables.
// RQ18: The low flag is set on every low byte wrap in any mode.
// RQ19: Timer interrupt stays high while an enabled flag is set.
module rtwoc_top
   import rtwoc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_osc,
   output logic             timer_irq,
   output logic             irq
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   logic                   hof_q, hof_d;
   logic                   lof_q, lof_d;
   logic                   lie_q, lie_d;
   logic                   cap_q, cap_d;
   logic                   split_q, split_d;
   logic                   run_q, run_d;
   logic                   ext_q, ext_d;
   logic                   hsel_q, hsel_d;
   logic                   lsel_q, lsel_d;
   logic                   tie_q, tie_d;
   rtwoc_byte_type         rld_lo_q, rld_lo_d;
   rtwoc_byte_type         rld_hi_q, rld_hi_d;
   logic [`RTWOC_EV_W-1:0] ev_stat_q, ev_stat_d;
   logic [`RTWOC_EV_W-1:0] ev_mask_q, ev_mask_d;
   logic [`RTWOC_EV_W-1:0] ev_set;
   logic                   ack_q, ack_d;
   logic [31:0]            dat_q, dat_d;
   logic                   tirq_q, tirq_d;
   logic                   irq_q, irq_d;

   logic                   div12_tick;
   logic                   ext8_tick;
   logic                   ext8_fall;
   rtwoc_src_type          src_lo;
   rtwoc_src_type          src_hi;
   logic                   tick_lo;
   logic                   tick_hi;
   logic                   lo_inc, hi_inc;
   logic                   lo_load, hi_load;
   logic                   lo_wrap, hi_wrap;
   logic                   full_ovf;
   logic                   cap_evt;
   rtwoc_byte_type         cnt_lo, cnt_hi;
   logic                   req;
   logic                   wr_en;
   logic [7:0]             adr_w;
   logic                   wr_cnt_lo, wr_cnt_hi;

   // -------------------------------------------------------------------------
   // Clock sources
   // -------------------------------------------------------------------------
   rtwoc_clk_src u_clk_src (
      .clk        (clk),
      .rst        (rst),
      .ext_osc    (ext_osc),
      .div12_tick (div12_tick),
      .ext8_tick  (ext8_tick),
      .ext8_fall  (ext8_fall)
   );

   function automatic logic src_tick(input rtwoc_src_type s, input logic d12, input logic e8);
      logic t;
      t = 1'b0;
      unique case (s)
         RTWOC_SRC_SYS:   t = 1'b1;
         RTWOC_SRC_DIV12: t = d12;
         RTWOC_SRC_EXT8:  t = e8;
         default:         t = 1'b0;
      endcase
      return t;
   endfunction : src_tick

   // Capture mode never counts the low byte from the oscillator it is measuring.
   always_comb begin
      if (lsel_q) begin
         src_lo = RTWOC_SRC_SYS; // RQ8
      end else if (ext_q && !cap_q) begin
         src_lo = RTWOC_SRC_EXT8; // RQ8
      end else begin
         src_lo = RTWOC_SRC_DIV12; // RQ12
      end
      if (hsel_q) begin
         src_hi = RTWOC_SRC_SYS; // RQ8
      end else if (ext_q) begin
         src_hi = RTWOC_SRC_EXT8; // RQ8
      end else begin
         src_hi = RTWOC_SRC_DIV12; // RQ8
      end
   end

   assign tick_lo = src_tick(src_lo, div12_tick, ext8_tick); // RQ2
   assign tick_hi = src_tick(src_hi, div12_tick, ext8_tick); // RQ2

   // -------------------------------------------------------------------------
   // Counter bytes
   // -------------------------------------------------------------------------
   always_comb begin
      if (split_q) begin
         lo_inc  = tick_lo; // RQ7
         hi_inc  = run_q && tick_hi; // RQ7
         lo_load = lo_wrap; // RQ6
         hi_load = hi_wrap; // RQ6
      end else begin
         lo_inc  = run_q && tick_lo; // RQ1
         hi_inc  = lo_wrap; // RQ1
         lo_load = full_ovf && !cap_q; // RQ3
         hi_load = full_ovf && !cap_q; // RQ3
      end
   end

   assign full_ovf  = !split_q && hi_wrap;
   assign cap_evt   = cap_q && ext8_fall; // RQ14
   assign wr_cnt_lo = wr_en && (adr_w == `RTWOC_OFS_CNT_LO);
   assign wr_cnt_hi = wr_en && (adr_w == `RTWOC_OFS_CNT_HI);

   rtwoc_byte_cnt u_cnt_lo (
      .clk      (clk),
      .rst      (rst),
      .inc      (lo_inc),
      .load     (lo_load),
      .load_val (rld_lo_q),
      .wr       (wr_cnt_lo),
      .wr_val   (wb_dat_i[7:0]),
      .cnt_q    (cnt_lo),
      .wrap     (lo_wrap)
   );

   rtwoc_byte_cnt u_cnt_hi (
      .clk      (clk),
      .rst      (rst),
      .inc      (hi_inc),
      .load     (hi_load),
      .load_val (rld_hi_q),
      .wr       (wr_cnt_hi),
      .wr_val   (wb_dat_i[7:0]),
      .cnt_q    (cnt_hi),
      .wrap     (hi_wrap)
   );

   // -------------------------------------------------------------------------
   // Bus slave
   // -------------------------------------------------------------------------
   // A write lands on the edge where the master sees ack, so read data and the
   // stored value are never a cycle apart.
   assign req   = wb_cyc_i && wb_stb_i;
   assign adr_w = {wb_adr_i[7:2], 2'b00};
   assign wr_en = req && ack_q && wb_we_i && wb_sel_i[0];

   always_comb begin
      ack_d = req && !ack_q;
      dat_d = 32'h0000_0000;
      if (ack_d && !wb_we_i) begin
         unique case (adr_w)
            `RTWOC_OFS_CTRL: begin
               dat_d[`RTWOC_CTL_HOF]   = hof_q;
               dat_d[`RTWOC_CTL_LOF]   = lof_q;
               dat_d[`RTWOC_CTL_LIE]   = lie_q;
               dat_d[`RTWOC_CTL_CAP]   = cap_q;
               dat_d[`RTWOC_CTL_SPLIT] = split_q;
               dat_d[`RTWOC_CTL_RUN]   = run_q;
               dat_d[`RTWOC_CTL_EXT]   = ext_q;
            end
            `RTWOC_OFS_CLKCTL: begin
               dat_d[`RTWOC_CKC_HSEL] = hsel_q;
               dat_d[`RTWOC_CKC_LSEL] = lsel_q;
            end
            `RTWOC_OFS_RLD_LO:  dat_d[7:0] = rld_lo_q;
            `RTWOC_OFS_RLD_HI:  dat_d[7:0] = rld_hi_q;
            `RTWOC_OFS_CNT_LO:  dat_d[7:0] = cnt_lo;
            `RTWOC_OFS_CNT_HI:  dat_d[7:0] = cnt_hi;
            `RTWOC_OFS_EV_STAT: dat_d[`RTWOC_EV_W-1:0] = ev_stat_q;
            `RTWOC_OFS_EV_MASK: dat_d[`RTWOC_EV_W-1:0] = ev_mask_q;
            `RTWOC_OFS_TIRQ_EN: dat_d[`RTWOC_TIE_BIT] = tie_q;
            default:            dat_d = 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Control, reload and event registers
   // -------------------------------------------------------------------------
   always_comb begin
      hof_d     = hof_q;
      lof_d     = lof_q;
      lie_d     = lie_q;
      cap_d     = cap_q;
      split_d   = split_q;
      run_d     = run_q;
      ext_d     = ext_q;
      hsel_d    = hsel_q;
      lsel_d    = lsel_q;
      tie_d     = tie_q;
      rld_lo_d  = rld_lo_q;
      rld_hi_d  = rld_hi_q;
      ev_mask_d = ev_mask_q;
      ev_stat_d = ev_stat_q;
      if (wr_en) begin
         unique case (adr_w)
            `RTWOC_OFS_CTRL: begin
               hof_d   = wb_dat_i[`RTWOC_CTL_HOF]; // RQ11
               lof_d   = wb_dat_i[`RTWOC_CTL_LOF]; // RQ11
               lie_d   = wb_dat_i[`RTWOC_CTL_LIE];
               cap_d   = wb_dat_i[`RTWOC_CTL_CAP]; // RQ17
               split_d = wb_dat_i[`RTWOC_CTL_SPLIT]; // RQ1
               run_d   = wb_dat_i[`RTWOC_CTL_RUN];
               ext_d   = wb_dat_i[`RTWOC_CTL_EXT];
            end
            `RTWOC_OFS_CLKCTL: begin
               hsel_d = wb_dat_i[`RTWOC_CKC_HSEL];
               lsel_d = wb_dat_i[`RTWOC_CKC_LSEL];
            end
            `RTWOC_OFS_RLD_LO:  rld_lo_d = wb_dat_i[7:0];
            `RTWOC_OFS_RLD_HI:  rld_hi_d = wb_dat_i[7:0];
            `RTWOC_OFS_EV_STAT: ev_stat_d = ev_stat_q & ~wb_dat_i[`RTWOC_EV_W-1:0];
            `RTWOC_OFS_EV_MASK: ev_mask_d = wb_dat_i[`RTWOC_EV_W-1:0];
            `RTWOC_OFS_TIRQ_EN: tie_d = wb_dat_i[`RTWOC_TIE_BIT];
            default: begin
            end
         endcase
      end
      // A capture wins over a software write of the reload bytes.
      if (cap_evt) begin
         rld_lo_d = cnt_lo; // RQ13
         rld_hi_d = cnt_hi; // RQ13
      end
      // Hardware sets win over a clear in the same cycle; nothing clears here.
      if (hi_wrap || cap_evt) begin
         hof_d = 1'b1; // RQ3 RQ9 RQ13
      end
      if (lo_wrap) begin
         lof_d = 1'b1; // RQ9 RQ18
      end
      ev_set                = '0;
      ev_set[`RTWOC_EV_HOF] = hi_wrap;
      ev_set[`RTWOC_EV_LOF] = lo_wrap;
      ev_set[`RTWOC_EV_CAP] = cap_evt;
      ev_stat_d             = ev_stat_d | ev_set;
   end

   // -------------------------------------------------------------------------
   // Interrupt outputs
   // -------------------------------------------------------------------------
   always_comb begin
      tirq_d = tie_q && (hof_q || (lie_q && lof_q)); // RQ4 RQ5 RQ10 RQ19
      irq_d  = |(ev_stat_q & ev_mask_q);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hof_q     <= 1'b0;
         lof_q     <= 1'b0;
         lie_q     <= 1'b0;
         cap_q     <= 1'b0;
         split_q   <= 1'b0;
         run_q     <= 1'b0;
         ext_q     <= 1'b0;
         hsel_q    <= 1'b0;
         lsel_q    <= 1'b0;
         tie_q     <= 1'b0;
         rld_lo_q  <= `RTWOC_BYTE_RST;
         rld_hi_q  <= `RTWOC_BYTE_RST;
         ev_stat_q <= `RTWOC_EV_RST;
         ev_mask_q <= `RTWOC_EV_RST;
         ack_q     <= 1'b0;
         dat_q     <= 32'h0000_0000;
         tirq_q    <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         hof_q     <= hof_d;
         lof_q     <= lof_d;
         lie_q     <= lie_d;
         cap_q     <= cap_d;
         split_q   <= split_d;
         run_q     <= run_d;
         ext_q     <= ext_d;
         hsel_q    <= hsel_d;
         lsel_q    <= lsel_d;
         tie_q     <= tie_d;
         rld_lo_q  <= rld_lo_d;
         rld_hi_q  <= rld_hi_d;
         ev_stat_q <= ev_stat_d;
         ev_mask_q <= ev_mask_d;
         ack_q     <= ack_d;
         dat_q     <= dat_d;
         tirq_q    <= tirq_d;
         irq_q     <= irq_d;
      end
   end

   assign wb_ack_o  = ack_q;
   assign wb_dat_o  = dat_q;
   assign timer_irq = tirq_q;
   assign irq       = irq_q;

endmodule : rtwoc_top
`default_nettype wire

// *** testbench/rtwoc_assertions.sv ***
// Port-level assertions for the reload timer.
`timescale 1ns/1ps
`default_nettype none

module rtwoc_assertions
   import rtwoc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        ext_osc,
   input wire logic        timer_irq,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic req;
   logic rd;
   logic wdone;
   assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd    = req && !wb_we_i;
   assign wdone = wb_ack_o && wb_we_i;

   // -------------------------------------------------------------------------
   // Bus and interrupt relations
   // -------------------------------------------------------------------------
   property p_ack_next; req |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
   a_dat_hi: assert property (p_dat_hi) else $error("upper read bits not zero");
   property p_unmapped; rd && wb_adr_i > 8'h23 |=> wb_dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctl_unused; rd && wb_adr_i[7:2] == 6'h00 |=> !wb_dat_o[1]; endproperty
   a_ctl_unused: assert property (p_ctl_unused) else $error("control bit 1 not zero");
   property p_stat_w; rd && wb_adr_i[7:2] == 6'h06 |=> wb_dat_o[7:3] == 5'h00; endproperty
   a_stat_w: assert property (p_stat_w) else $error("status spare bits set");
   property p_rst_quiet; $fell(rst) |-> !timer_irq && !irq && !wb_ack_o; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
   property p_flag_hold; $fell(timer_irq) |-> $past(wdone, 2) || $past(wdone, 3); endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("timer irq fell unprompted");
   property p_irq_hold; $fell(irq) |-> $past(wdone, 2) || $past(wdone, 3); endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("event irq fell unprompted");
endmodule : rtwoc_assertions

`default_nettype wire

// *** testbench/rtwoc_tb_top.sv ***
// Self-checking bench for the reload timer.
`timescale 1ns/1ps
`default_nettype none
`include "rtwoc_defines.svh"

module rtwoc_tb_top
   import rtwoc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [2:0]  osc_ph = 3'h0;
   logic        ext_osc;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        timer_irq;
   logic        irq;
   logic [7:0]  q;
   int          n;
   int          err_count = 0;
   int          compares = 0;
   int          cyc_n = 0;

   rtwoc_top i_dut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
                    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_osc, .timer_irq, .irq);

   // The oscillator runs at one eighth of the clock, so its /8 tick is every 64 cycles.
   assign ext_osc = osc_ph[2];
   always #10 clk = ~clk;
   always @(posedge clk) osc_ph <= osc_ph + 3'h1;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   task automatic conclude();
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // The master waits for ack however long it takes; only the cycle ceiling ends a hang.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d); wb(1'b1, a, d); endtask : wr
   task automatic rd(input logic [7:0] a); wb(1'b0, a, 8'h00); endtask : rd

   task automatic wait_ti(input int lo, input int hi);
      n = 0;
      while (timer_irq !== 1'b1 && n < 1200) begin
         @(posedge clk);
         n++;
      end
      chk({15'h0, n >= lo && n <= hi}, 16'h1);
   endtask : wait_ti

   task automatic setup(input logic [7:0] ckc, input logic [15:0] rl, input logic [15:0] c);
      wr(`RTWOC_OFS_CTRL, 8'h00);
      wr(`RTWOC_OFS_CLKCTL, ckc);
      wr(`RTWOC_OFS_RLD_LO, rl[7:0]);
      wr(`RTWOC_OFS_RLD_HI, rl[15:8]);
      wr(`RTWOC_OFS_CNT_LO, c[7:0]);
      wr(`RTWOC_OFS_CNT_HI, c[15:8]);
      wr(`RTWOC_OFS_TIRQ_EN, 8'h01);
   endtask : setup

   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_regs();
      for (int a = 0; a <= 36; a += 4) begin
         rd(8'(a));
         chk({8'h0, q}, 16'h0000);
      end
      wr(8'h24, 8'hFF);
      rd(8'h24);
      chk({8'h0, q}, 16'h0000);
      wr(`RTWOC_OFS_CTRL, 8'hFF);
      rd(`RTWOC_OFS_CTRL);
      chk({8'h0, q}, 16'h00FD);
      wr(`RTWOC_OFS_CTRL, 8'h00);
   endtask : t_regs

   task automatic t_rate(input logic [7:0] ckc, input logic ext, input int lo, input int hi);
      setup(ckc, 16'h1234, 16'hFFF8);
      wr(`RTWOC_OFS_CTRL, {7'h02, ext});
      wait_ti(lo, hi);
      wr(`RTWOC_OFS_CTRL, 8'h80);
      rd(`RTWOC_OFS_CTRL);
      chk({15'h0, q[7]}, 16'h1);
      chk({15'h0, timer_irq}, 16'h1);
      rd(`RTWOC_OFS_CNT_HI);
      chk({8'h0, q}, 16'h0012);
      wr(`RTWOC_OFS_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      chk({15'h0, timer_irq}, 16'h0);
   endtask : t_rate

   task automatic t_low();
      setup(8'h40, 16'h0000, 16'h00F8);
      wr(`RTWOC_OFS_CTRL, 8'h24);
      wait_ti(5, 14);
      rd(`RTWOC_OFS_CTRL);
      chk({14'h0, q[7:6]}, 16'h0001);
      wr(`RTWOC_OFS_CTRL, 8'h40);
      rd(`RTWOC_OFS_CNT_HI);
      chk({8'h0, q}, 16'h0001);
      chk({15'h0, timer_irq}, 16'h0);
   endtask : t_low

   task automatic t_split();
      setup(8'hC0, 16'hA0F0, 16'h55FE);
      wr(`RTWOC_OFS_CTRL, 8'h08);
      repeat (20) @(posedge clk);
      rd(`RTWOC_OFS_CTRL);
      chk({8'h0, q}, 16'h0048);
      chk({15'h0, timer_irq}, 16'h0);
      rd(`RTWOC_OFS_CNT_HI);
      chk({8'h0, q}, 16'h0055);
      rd(`RTWOC_OFS_CNT_LO);
      chk({15'h0, q >= 8'hF0}, 16'h1);
      wr(`RTWOC_OFS_CTRL, 8'h4C);
      wait_ti(166, 178);
      rd(`RTWOC_OFS_CNT_HI);
      chk({15'h0, q >= 8'hA0}, 16'h1);
      rd(`RTWOC_OFS_CTRL);
      chk({15'h0, q[7]}, 16'h1);
      wr(`RTWOC_OFS_CTRL, 8'h68);
      repeat (2) @(posedge clk);
      chk({15'h0, timer_irq}, 16'h1);
      wr(`RTWOC_OFS_CTRL, 8'h00);
   endtask : t_split

   task automatic t_events();
      wr(`RTWOC_OFS_EV_STAT, 8'h07);
      rd(`RTWOC_OFS_EV_STAT);
      chk({8'h0, q}, 16'h0000);
      setup(8'h40, 16'h0000, 16'hFFFE);
      wr(`RTWOC_OFS_CTRL, 8'h04);
      wait_ti(0, 8);
      wr(`RTWOC_OFS_CTRL, 8'h00);
      chk({15'h0, irq}, 16'h0);
      rd(`RTWOC_OFS_EV_STAT);
      chk({15'h0, q[0]}, 16'h1);
      wr(`RTWOC_OFS_EV_MASK, 8'h01);
      repeat (2) @(posedge clk);
      chk({15'h0, irq}, 16'h1);
      wr(`RTWOC_OFS_EV_STAT, 8'h01);
      repeat (2) @(posedge clk);
      chk({15'h0, irq}, 16'h0);
      wr(`RTWOC_OFS_EV_MASK, 8'h00);
   endtask : t_events

   task automatic t_capture();
      logic [15:0] v1;
      setup(8'h40, 16'h0000, 16'h0000);
      wr(`RTWOC_OFS_EV_MASK, 8'h04);
      wr(`RTWOC_OFS_CTRL, 8'h14);
      wait_ti(0, 80);
      chk({15'h0, irq}, 16'h1);
      rd(`RTWOC_OFS_RLD_LO);
      v1[7:0] = q;
      rd(`RTWOC_OFS_RLD_HI);
      v1[15:8] = q;
      wr(`RTWOC_OFS_CTRL, 8'h14);
      // The interrupt output drops one cycle after the flag clear lands.
      @(posedge clk);
      wait_ti(30, 66);
      rd(`RTWOC_OFS_RLD_LO);
      v1 = {8'h00, q} - v1;
      rd(`RTWOC_OFS_RLD_HI);
      chk(v1 + {q, 8'h00}, 16'h0040);
      wr(`RTWOC_OFS_CTRL, 8'h00);
   endtask : t_capture

   // A hang in any wait ends here instead of running forever.
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         chk(16'h0, 16'h1);
         conclude();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_rate(8'h40, 1'b0, 5, 14);
      t_rate(8'h00, 1'b0, 80, 115);
      t_rate(8'h00, 1'b1, 440, 590);
      t_low();
      t_split();
      t_events();
      t_capture();
      conclude();
   end
endmodule : rtwoc_tb_top

bind rtwoc_top rtwoc_assertions i_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_osc, .timer_irq, .irq);

`default_nettype wire
